// ---- src/hcl_pkg.sv ----
// Shared constants and helpers for the Hall signal conditioning path.
package hcl_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADR_LCLP_LO = 8'h02;
    localparam logic [7:0] ADR_LCLP_HI = 8'h03;
    localparam logic [7:0] ADR_HCLP_LO = 8'h04;
    localparam logic [7:0] ADR_HCLP_HI = 8'h05;
    localparam logic [7:0] ADR_OFS_LO  = 8'h06;
    localparam logic [7:0] ADR_OFS_HI  = 8'h07;
    localparam logic [7:0] ADR_GAIN_LO = 8'h08;
    localparam logic [7:0] ADR_GAIN_HI = 8'h09;
    localparam logic [7:0] ADR_MODE    = 8'h0C;
    localparam logic [7:0] ADR_TCL     = 8'h0E;
    localparam logic [7:0] ADR_TCQ     = 8'h0F;
    localparam logic [7:0] ADR_FLD_LO  = 8'h18;
    localparam logic [7:0] ADR_FLD_HI  = 8'h19;
    // Mode field positions.
    localparam int MODE_RNG_LSB = 0;
    localparam int MODE_FLT_LSB = 3;
    // Reset values (blank storage).
    localparam logic [5:0]  MODE_RST = 6'h00;
    localparam logic [12:0] CLM_RST  = 13'h0000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0]  TCL_RST  = 8'h00;
    localparam logic [5:0]  TCQ_RST  = 6'h00;
    // Stored-to-effective bit inversions.
    localparam logic [15:0] GAIN_INV = 16'h2000;
    localparam logic [15:0] OFS_INV  = 16'h1000;
    localparam logic [12:0] HCLP_INV = 13'h1FFF;
    // Range scale in Q8, relative to the widest range.
    localparam logic [10:0] RNG_Q8_100 = 11'h180;
    localparam logic [10:0] RNG_Q8_30  = 11'h500;
    localparam logic [10:0] RNG_Q8_60  = 11'h280;
    localparam logic [10:0] RNG_Q8_80  = 11'h1E0;
    localparam logic [10:0] RNG_Q8_150 = 11'h100;
    localparam logic [2:0]  RNG_WIDE   = 3'h4;
    // Filter smoothing shifts; each halving of corner adds one.
    localparam logic [2:0] FLT_K_2K  = 3'h1;
    localparam logic [2:0] FLT_K_1K  = 3'h2;
    localparam logic [2:0] FLT_K_500 = 3'h3;
    localparam logic [2:0] FLT_K_250 = 3'h4;
    localparam logic [2:0] FLT_K_125 = 3'h5;
    localparam logic [2:0] FLT_K_62  = 3'h6;
    // Per-corner trim of the field value, Q8 (1.0 by default).
    localparam logic [8:0] FLT_Q8_WIDE   = 9'h100;
    localparam logic [8:0] FLT_Q8_NARROW = 9'h100;
    localparam int FLT_FRAC = 6;
    // Output arithmetic: 65536 field steps at unity gain span supply.
    localparam int OUT_PROD_SHIFT = 16;
    localparam int OFS_SHIFT      = 1;
    localparam logic [12:0] DAC_MAX = 13'h1FFF;

    // Saturate a wide signed value into 16 bits.
    function automatic logic signed [15:0] hcl_sat16(input logic signed [31:0] v);
        if (v > 32'sd32767) begin
            return 16'sh7FFF;
        end else if (v < -32'sd32768) begin
            return -16'sh8000;
        end
        return v[15:0];
    endfunction
endpackage

// ---- src/hcl_lpf.sv ----
// First-order digital low-pass filter with selectable smoothing shift.
`timescale 1ns/1ps
`default_nettype none
module hcl_lpf
    import hcl_pkg::*;
(
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Sample in.
    input  wire logic               in_valid,
    input  wire logic signed [15:0] in_data,
    input  wire logic [2:0]         shift_k,
    // Filtered sample out.
    output var  logic               out_valid,
    output var  logic signed [15:0] out_data
);
    // Accumulator with fraction bits keeps slow corners from stalling.
    logic signed [21:0] acc_r;
    wire  logic signed [22:0] diff = {in_data[15], in_data, {FLT_FRAC{1'b0}}} -
                                     {acc_r[21], acc_r};
    wire  logic signed [22:0] step = diff >>> shift_k;
    wire  logic signed [22:0] acc_sum = {acc_r[21], acc_r} + step;

    // Update once per sample; the result never leaves the input span.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r     <= 22'sh0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                acc_r <= acc_sum[21:0];
            end
        end
    end

    // Integer part is the filtered field.
    assign out_data = acc_r[21:FLT_FRAC];
endmodule
`default_nettype wire

// ---- src/hcl_out_stage.sv ----
// Gain, offset, saturation and clamp stage feeding the output converter.
`timescale 1ns/1ps
`default_nettype none
module hcl_out_stage
    import hcl_pkg::*;
(
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Filtered field and effective parameters.
    input  wire logic               in_valid,
    input  wire logic signed [15:0] field,
    input  wire logic signed [15:0] gain,
    input  wire logic signed [15:0] ofs,
    input  wire logic [12:0]        clamp_lo,
    input  wire logic [12:0]        clamp_hi,
    // Converter code.
    output var  logic               out_valid,
    output var  logic [12:0]        out_code
);
    logic signed [31:0] prod_r;
    logic               prod_v_r;

    // Scaled product plus offset, both in supply/8192 units.
    wire logic signed [17:0] prod_q = {{2{prod_r[31]}}, prod_r[31:OUT_PROD_SHIFT]};
    wire logic signed [17:0] ofs_q  = {{3{ofs[15]}}, ofs[15:OFS_SHIFT]};
    wire logic signed [17:0] sum    = prod_q + ofs_q;
    // Saturate rather than wrap, then apply the clamp window.
    wire logic [12:0] sat  = sum[17] ? 13'h0000 :
                             (sum > $signed({5'h00, DAC_MAX})) ? DAC_MAX : sum[12:0];
    wire logic [12:0] hi_c = (sat > clamp_hi) ? clamp_hi : sat;
    wire logic [12:0] clmp = (hi_c < clamp_lo) ? clamp_lo : hi_c;

    // Two-stage pipe: multiply, then add and limit.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prod_r    <= 32'sh0;
            prod_v_r  <= 1'b0;
            out_code  <= 13'h0000;
            out_valid <= 1'b0;
        end else begin
            prod_v_r  <= in_valid;
            out_valid <= prod_v_r;
            if (in_valid) begin
                prod_r <= field * gain;
            end
            if (prod_v_r) begin
                out_code <= clmp;
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/hcl_cond.sv ----
// Top of the Hall signal conditioning path: registers, scaling, filter, output.
`timescale 1ns/1ps
`default_nettype none
module hcl_cond (
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    // Converted samples from the front end.
    input  wire logic        ADC_VALID,
    input  wire logic [15:0] ADC_DATA,
    // Register access port.
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [7:0]  REG_RDATA,
    // Front-end controls.
    output var  logic [2:0]  FE_RANGE,
    output var  logic [7:0]  FE_TC_LIN,
    output var  logic [5:0]  FE_TC_QUAD,
    // Output converter.
    output var  logic        DAC_VALID,
    output var  logic [12:0] DAC_CODE
);
    import hcl_pkg::*;

    // ************************************************************
    // Stored parameters
    // ************************************************************

    // Range and filter selection word.
    logic [5:0]  mode_r;
    // Low and high clamp, as stored.
    logic [12:0] lclp_r;
    logic [12:0] hclp_r;
    // Quiescent offset and gain, as stored.
    logic [15:0] ofs_r;
    logic [15:0] gain_r;
    // Temperature coefficients for the analog bias.
    logic [7:0]  tcl_r;
    logic [5:0]  tcq_r;

    // ************************************************************
    // Write decode
    // ************************************************************

    // One strobe per byte lane; writes land the cycle after.
    wire logic wr_lclp_lo = REG_WR && (REG_ADDR == ADR_LCLP_LO);
    wire logic wr_lclp_hi = REG_WR && (REG_ADDR == ADR_LCLP_HI);
    wire logic wr_hclp_lo = REG_WR && (REG_ADDR == ADR_HCLP_LO);
    wire logic wr_hclp_hi = REG_WR && (REG_ADDR == ADR_HCLP_HI);
    wire logic wr_ofs_lo  = REG_WR && (REG_ADDR == ADR_OFS_LO);
    wire logic wr_ofs_hi  = REG_WR && (REG_ADDR == ADR_OFS_HI);
    wire logic wr_gain_lo = REG_WR && (REG_ADDR == ADR_GAIN_LO);
    wire logic wr_gain_hi = REG_WR && (REG_ADDR == ADR_GAIN_HI);
    wire logic wr_mode    = REG_WR && (REG_ADDR == ADR_MODE);
    wire logic wr_tcl     = REG_WR && (REG_ADDR == ADR_TCL);
    wire logic wr_tcq     = REG_WR && (REG_ADDR == ADR_TCQ);

    // Mode word; only six bits exist.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_r <= MODE_RST;
        end else if (wr_mode) begin
            mode_r <= REG_WDATA[5:0];
        end
    end

    // Clamps are thirteen bits; upper byte holds bits 12..8.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lclp_r <= CLM_RST;
            hclp_r <= CLM_RST;
        end else begin
            if (wr_lclp_lo) begin
                lclp_r[7:0] <= REG_WDATA;
            end
            if (wr_lclp_hi) begin
                lclp_r[12:8] <= REG_WDATA[4:0];
            end
            if (wr_hclp_lo) begin
                hclp_r[7:0] <= REG_WDATA;
            end
            if (wr_hclp_hi) begin
                hclp_r[12:8] <= REG_WDATA[4:0];
            end
        end
    end

    // Offset and gain words.
    // A half-written word is used at once; software writes
    // both bytes back to back to avoid a brief odd output.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ofs_r  <= WORD_RST;
            gain_r <= WORD_RST;
        end else begin
            if (wr_ofs_lo) begin
                ofs_r[7:0] <= REG_WDATA;
            end
            if (wr_ofs_hi) begin
                ofs_r[15:8] <= REG_WDATA;
            end
            if (wr_gain_lo) begin
                gain_r[7:0] <= REG_WDATA;
            end
            if (wr_gain_hi) begin
                gain_r[15:8] <= REG_WDATA;
            end
        end
    end

    // Temperature coefficients only steer the analog bias.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tcl_r <= TCL_RST;
            tcq_r <= TCQ_RST;
        end else begin
            if (wr_tcl) begin
                tcl_r <= REG_WDATA;
            end
            if (wr_tcq) begin
                tcq_r <= REG_WDATA[5:0];
            end
        end
    end

    // ************************************************************
    // Mode decode
    // ************************************************************

    wire logic [2:0] rng_code = mode_r[MODE_RNG_LSB +: 3];
    wire logic [2:0] flt_code = mode_r[MODE_FLT_LSB +: 3];

    // range to scale.
    // The front end converts over the widest span; narrower
    // ranges are digital gain, which costs resolution.
    wire logic [10:0] rng_q8 =
        (rng_code == 3'h0) ? RNG_Q8_100 :
        (rng_code == 3'h1) ? RNG_Q8_30  :
        (rng_code == 3'h2) ? RNG_Q8_60  :
        (rng_code == 3'h3) ? RNG_Q8_80  : RNG_Q8_150;

    // Canonical range code for the front end.
    wire logic [2:0] rng_fe = rng_code[2] ? RNG_WIDE : rng_code;

    wire logic [2:0] flt_k =
        (flt_code == 3'h0) ? FLT_K_500 :
        (flt_code == 3'h1) ? FLT_K_125 :
        (flt_code == 3'h2) ? FLT_K_250 :
        (flt_code == 3'h3) ? FLT_K_62  :
        (flt_code == 3'h4) ? FLT_K_1K  : FLT_K_2K;

    // Per-corner trim; wide corners and narrow ones use the same 1.0 (9'h100).
    wire logic [8:0] flt_q8 = (flt_k < FLT_K_500) ? FLT_Q8_WIDE : FLT_Q8_NARROW;

    wire logic [19:0] scl_full = rng_q8 * flt_q8;
    wire logic [11:0] scl_q8   = scl_full[19:8];

    // ************************************************************
    // Input scaling
    // ************************************************************

    logic               scl_v_r;
    logic signed [15:0] scl_r;

    // sample sign kept as converted.
    // North faces give positive codes, so no negation here.
    wire logic signed [28:0] scl_prod = $signed(ADC_DATA) * $signed({1'b0, scl_q8});
    wire logic signed [31:0] scl_wide = {{11{scl_prod[28]}}, scl_prod[28:8]};

    // Register the scaled sample; narrow ranges saturate.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            scl_r   <= 16'sh0;
            scl_v_r <= 1'b0;
        end else begin
            scl_v_r <= ADC_VALID;
            if (ADC_VALID) begin
                scl_r <= hcl_sat16(scl_wide);
            end
        end
    end

    // ************************************************************
    // Low-pass filter
    // ************************************************************

    logic               flt_v;
    logic signed [15:0] flt_data;

    hcl_lpf u_lpf (
        .clk       (MCLK),
        .rst_n     (RESET_N),
        .in_valid  (scl_v_r),
        .in_data   (scl_r),
        .shift_k   (flt_k),
        .out_valid (flt_v),
        .out_data  (flt_data)
    );

    // field value is the filter output.
    // It spans the full sixteen-bit signed range.
    wire logic [15:0] fld = flt_data;

    // ************************************************************
    // Effective parameters
    // ************************************************************

    wire logic signed [15:0] gain_eff = gain_r ^ GAIN_INV;
    wire logic signed [15:0] ofs_eff  = ofs_r ^ OFS_INV;

    wire logic [12:0] hclp_eff = hclp_r ^ HCLP_INV;

    // ************************************************************
    // Output stage
    // ************************************************************

    hcl_out_stage u_out (
        .clk       (MCLK),
        .rst_n     (RESET_N),
        .in_valid  (flt_v),
        .field     (flt_data),
        .gain      (gain_eff),
        .ofs       (ofs_eff),
        .clamp_lo  (lclp_r),
        .clamp_hi  (hclp_eff),
        .out_valid (DAC_VALID),
        .out_code  (DAC_CODE)
    );

    // ************************************************************
    // Read path
    // ************************************************************

    // Stored values read back as written, not as inverted.
    // Unmapped addresses read zero.
    wire logic [7:0] rd_mux =
        (REG_ADDR == ADR_LCLP_LO) ? lclp_r[7:0]        :
        (REG_ADDR == ADR_LCLP_HI) ? {3'h0, lclp_r[12:8]} :
        (REG_ADDR == ADR_HCLP_LO) ? hclp_r[7:0]        :
        (REG_ADDR == ADR_HCLP_HI) ? {3'h0, hclp_r[12:8]} :
        (REG_ADDR == ADR_OFS_LO)  ? ofs_r[7:0]         :
        (REG_ADDR == ADR_OFS_HI)  ? ofs_r[15:8]        :
        (REG_ADDR == ADR_GAIN_LO) ? gain_r[7:0]        :
        (REG_ADDR == ADR_GAIN_HI) ? gain_r[15:8]       :
        (REG_ADDR == ADR_MODE)    ? {2'h0, mode_r}     :
        (REG_ADDR == ADR_TCL)     ? tcl_r              :
        (REG_ADDR == ADR_TCQ)     ? {2'h0, tcq_r}      :
        (REG_ADDR == ADR_FLD_LO)  ? fld[7:0]           :
        (REG_ADDR == ADR_FLD_HI)  ? fld[15:8]          : 8'h00;

    // Read data registered; holds until the next read.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end
    end

    // ************************************************************
    // Front-end controls
    // ************************************************************

    // Registered copies so every output leaves a flop.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FE_RANGE   <= 3'h0;
            FE_TC_LIN  <= TCL_RST;
            FE_TC_QUAD <= TCQ_RST;
        end else begin
            FE_RANGE   <= rng_fe;
            FE_TC_LIN  <= tcl_r;
            FE_TC_QUAD <= tcq_r;
        end
    end
endmodule
`default_nettype wire

// ---- test/hcl_cond_props.sv ----
// Port-level assertions for the Hall conditioning top.
`timescale 1ns/1ps
`default_nettype none
module hcl_cond_chk (
    // Clock and reset.
    input wire logic        MCLK,
    input wire logic        RESET_N,
    // Sample stream and register port.
    input wire logic        ADC_VALID,
    input wire logic [15:0] ADC_DATA,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_RDATA,
    // Front-end and converter outputs.
    input wire logic [2:0]  FE_RANGE,
    input wire logic [7:0]  FE_TC_LIN,
    input wire logic [5:0]  FE_TC_QUAD,
    input wire logic        DAC_VALID,
    input wire logic [12:0] DAC_CODE
);
    import hcl_pkg::*;
    logic [12:0] lo_r;    // Shadow of the stored low clamp.
    logic [12:0] hi_r;    // Shadow of the stored high clamp.
    logic [12:0] hi_eff;  // High clamp as the arithmetic sees it.
    logic [2:0]  rng_w;   // Range code the front end should get.
    logic        mapped;  // Address decodes to a register.
    assign hi_eff = hi_r ^ HCLP_INV;
    assign rng_w  = (REG_WDATA[2:0] > 3'h3) ? 3'h4 : REG_WDATA[2:0];
    assign mapped = REG_ADDR inside {ADR_LCLP_LO, ADR_LCLP_HI, ADR_HCLP_LO, ADR_HCLP_HI,
        ADR_OFS_LO, ADR_OFS_HI, ADR_GAIN_LO, ADR_GAIN_HI, ADR_MODE, ADR_TCL, ADR_TCQ,
        ADR_FLD_LO, ADR_FLD_HI};
    // Shadow the clamps so the window can be judged without peeking inside.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lo_r <= 13'h0000;
            hi_r <= 13'h0000;
        end else if (REG_WR) begin
            case (REG_ADDR)
                ADR_LCLP_LO: lo_r[7:0] <= REG_WDATA;
                ADR_LCLP_HI: lo_r[12:8] <= REG_WDATA[4:0];
                ADR_HCLP_LO: hi_r[7:0] <= REG_WDATA;
                ADR_HCLP_HI: hi_r[12:8] <= REG_WDATA[4:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    chk_dac_latency: assert property (ADC_VALID |-> ##4 DAC_VALID)
        else $error("converter strobe missing four cycles after a sample");
    chk_dac_quiet: assert property (!ADC_VALID |-> ##4 !DAC_VALID)
        else $error("converter strobe without a sample");
    chk_code_holds: assert property (!DAC_VALID |-> $stable(DAC_CODE))
        else $error("converter code moved without a strobe");
    chk_range_code: assert property (REG_WR && REG_ADDR == ADR_MODE |-> ##2 FE_RANGE == $past(rng_w, 2))
        else $error("front-end range code wrong after mode write");
    chk_unmapped_zero: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
        else $error("unmapped read returned data");
    chk_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    chk_clamp_low: assert property (DAC_VALID |-> DAC_CODE >= lo_r)
        else $error("converter code below low clamp");
    chk_clamp_high: assert property (DAC_VALID && lo_r <= hi_eff |-> DAC_CODE <= hi_eff)
        else $error("converter code above high clamp");
    cov_sample: cover property (DAC_VALID);
    cov_at_low: cover property (DAC_VALID && DAC_CODE == lo_r && lo_r != 13'h0000);
    cov_fld_read: cover property (REG_RD && REG_ADDR == ADR_FLD_HI);
endmodule
bind hcl_cond hcl_cond_chk u_chk (
    .MCLK(MCLK), .RESET_N(RESET_N), .ADC_VALID(ADC_VALID), .ADC_DATA(ADC_DATA),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .FE_RANGE(FE_RANGE), .FE_TC_LIN(FE_TC_LIN),
    .FE_TC_QUAD(FE_TC_QUAD), .DAC_VALID(DAC_VALID), .DAC_CODE(DAC_CODE)
);
`default_nettype wire

// ---- test/hcl_adc_model.sv ----
// Behavioural Hall front end that delivers converted samples.
`timescale 1ns/1ps
`default_nettype none
module hcl_adc_model (
    // Clock.
    input  wire logic        mclk,
    // Sample stream.
    output var  logic        adc_valid,
    output var  logic [15:0] adc_data
);
    initial begin
        adc_valid = 1'b0;
        adc_data  = 16'h0000;
    end
    // north reads positive
    // One sample per call; the caller gives a signed field where north is positive.
    task automatic send(input logic [15:0] v, input int gap);
        adc_valid = 1'b1;
        adc_data  = v;
        @(posedge mclk);
        #1;
        if (gap > 0) begin
            adc_valid = 1'b0;
            // Idle bus carries junk so a stale sample can never look valid.
            adc_data  = ~v;
            repeat (gap) @(posedge mclk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// ---- test/test_hcl_cond.sv ----
// Self-checking bench for the Hall conditioning top.
`timescale 1ns/1ps
`default_nettype none
module test_hcl_cond;
    import hcl_pkg::*;
    logic        mclk;
    logic        reset_n;
    logic        adc_valid;
    logic [15:0] adc_data;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [2:0]  fe_range;
    logic [7:0]  fe_tc_lin;
    logic [5:0]  fe_tc_quad;
    logic        dac_valid;
    logic [12:0] dac_code;
    int          miscompares = 0;
    int          samples_checked = 0;
    logic [31:0] lfsr = 32'hBF44867C;
    logic [5:0]  mode_w = 6'h00;   // Mode the model believes is active.
    logic [15:0] gain_w;           // Stored gain word.
    logic [15:0] ofs_w;            // Stored offset word.
    logic [12:0] lo_w;             // Stored low clamp.
    logic [12:0] hi_w;             // Stored high clamp.
    int          acc = 0;          // Filter state of the model, six fraction bits.
    logic [12:0] exp_q[$];         // Codes still due at the converter.
    logic [7:0]  ra [11] = '{ADR_LCLP_LO, ADR_LCLP_HI, ADR_HCLP_LO, ADR_HCLP_HI, ADR_OFS_LO,
        ADR_OFS_HI, ADR_GAIN_LO, ADR_GAIN_HI, ADR_MODE, ADR_TCL, ADR_TCQ};
    logic [7:0]  rm [11] = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F,
        8'hFF, 8'h3F};

    hcl_cond DUT (
        .MCLK(mclk), .RESET_N(reset_n), .ADC_VALID(adc_valid), .ADC_DATA(adc_data),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .FE_RANGE(fe_range), .FE_TC_LIN(fe_tc_lin),
        .FE_TC_QUAD(fe_tc_quad), .DAC_VALID(dac_valid), .DAC_CODE(dac_code)
    );
    hcl_adc_model u_adc (.mclk(mclk), .adc_valid(adc_valid), .adc_data(adc_data));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
        return lfsr;
    endfunction
    function automatic int sx16(input logic [15:0] v);
        return int'($signed(v));
    endfunction
    // Range code to digital scale; codes above 3 all mean the widest range.
    function automatic int scale_of(input logic [2:0] c);
        case (c)
            3'h0: return int'(RNG_Q8_100);
            3'h1: return int'(RNG_Q8_30);
            3'h2: return int'(RNG_Q8_60);
            3'h3: return int'(RNG_Q8_80);
            default: return int'(RNG_Q8_150);
        endcase
    endfunction
    // Filter code to smoothing shift; codes above 4 all mean the fastest corner.
    function automatic int shift_of(input logic [2:0] c);
        case (c)
            3'h0: return int'(FLT_K_500);
            3'h1: return int'(FLT_K_125);
            3'h2: return int'(FLT_K_250);
            3'h3: return int'(FLT_K_62);
            3'h4: return int'(FLT_K_1K);
            default: return int'(FLT_K_2K);
        endcase
    endfunction
    // Gain, then offset, then saturate, then clamp; low clamp wins last.
    function automatic logic [12:0] exp_code(input int f);
        int s;
        int h;
        int l;
        h = {19'h0, hi_w ^ HCLP_INV};
        l = {19'h0, lo_w};
        s = ((f * sx16(gain_w ^ GAIN_INV)) >>> 16) + (sx16(ofs_w ^ OFS_INV) >>> 1);
        s = (s > 8191) ? 8191 : ((s < 0) ? 0 : s);
        s = (s > h) ? h : s;
        s = (s < l) ? l : s;
        return s[12:0];
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
        @(posedge mclk);
        #1;
    endtask
    task automatic set_par(input logic [15:0] g, input logic [15:0] v, input logic [12:0] l,
                           input logic [12:0] h);
        gain_w = g;
        ofs_w = v;
        lo_w = l;
        hi_w = h;
        wr(ADR_GAIN_LO, g[7:0]);
        wr(ADR_GAIN_HI, g[15:8]);
        wr(ADR_OFS_LO, v[7:0]);
        wr(ADR_OFS_HI, v[15:8]);
        wr(ADR_LCLP_LO, l[7:0]);
        wr(ADR_LCLP_HI, {3'h0, l[12:8]});
        wr(ADR_HCLP_LO, h[7:0]);
        wr(ADR_HCLP_HI, {3'h0, h[12:8]});
    endtask
    // The model steps first, so the queue already holds the code when it emerges.
    task automatic sample(input logic [15:0] v, input int gap);
        int sc;
        sc = (sx16(v) * scale_of(mode_w[2:0])) >>> 8;
        sc = (sc > 32767) ? 32767 : ((sc < -32768) ? -32768 : sc);
        acc = acc + (((sc <<< 6) - acc) >>> shift_of(mode_w[5:3]));
        exp_q.push_back(exp_code(acc >>> 6));
        u_adc.send(v, gap);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Every converter strobe is matched against the oldest outstanding code.
    always @(negedge mclk) begin
        if (reset_n === 1'b1 && dac_valid === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(dac_code, exp_q.pop_front());
            end else begin
                check(dac_code, ~dac_code);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares = miscompares + 1;
        close_out();
    end

    initial begin
        int          i;
        int          m;
        int          j;
        int          f;
        logic [31:0] r;
        logic [31:0] q;
        logic [7:0]  b;
        logic [7:0]  wv [11];
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        check({fe_range, dac_code}, 32'h0);
        // Blank storage reads zero everywhere, unmapped places included.
        for (i = 0; i < 11; i++) begin
            rd(ra[i], b);
            check(b, 8'h00);
        end
        rd(8'h0A, b);
        check(b, 8'h00);
        // Field value ignores writes.
        wr(ADR_FLD_LO, 8'hFF);
        rd(ADR_FLD_LO, b);
        check(b, 8'h00);
        for (i = 0; i < 11; i++) begin
            r = rnd();
            wv[i] = r[7:0];
            wr(ra[i], wv[i]);
            rd(ra[i], b);
            check(b, wv[i] & rm[i]);
        end
        check({fe_tc_quad, fe_tc_lin}, {wv[10][5:0], wv[9]});
        // Every mode code, with defaults, saturation, inverted window and random words.
        for (m = 0; m < 64; m++) begin
            mode_w = m[5:0];
            wr(ADR_MODE, {2'h0, mode_w});
            check(fe_range, (mode_w[2:0] > 3'h3) ? 3'h4 : mode_w[2:0]);
            r = rnd();
            q = rnd();
            case (m % 4)
                0: set_par(16'h0000, 16'h0000, 13'h0000, 13'h0000);
                1: set_par(16'h5FFF, r[15:0], 13'h0000, 13'h0000);
                2: set_par(r[15:0], r[31:16], 13'h1000, 13'h17FF);
                default: set_par(r[15:0], r[31:16], q[12:0], q[28:16]);
            endcase
            for (j = 0; j < 6; j++) begin
                r = rnd();
                sample((j == 0) ? 16'h7FFF : ((j == 1) ? 16'h8000 : r[15:0]),
                       (j == 5) ? 1 : int'(r[17:16]) % 3);
            end
            repeat (8) @(posedge mclk);
            #1;
            check(exp_q.size(), 0);
            f = acc >>> 6;
            rd(ADR_FLD_LO, b);
            rd(ADR_FLD_HI, wv[0]);
            check({wv[0], b}, f[15:0]);
        end
        close_out();
    end
endmodule
`default_nettype wire
